/* dv/srb_link_chk.sv */
// Purpose: Timing checks on the link between controller and device.
// Assumes: Every link signal is sampled with the reference clock.
// Notes: Command spacing is counted in link clock rises.
`timescale 1ns/10ps
`include "srb_params.svh"
module srb_link_chk (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic ck,
    input wire logic [2:0] cmd,
    input wire logic [1:0] ba,
    input wire logic [17:0] addr,
    input wire logic [7:0] dq,
    input wire logic dq_oe,
    input wire logic dqs,
    input wire logic dqs_oe
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    logic ck_d, rpre2, next_rpre2, rise, is_rd, is_mrs;
    logic [4:0] al, next_al;
    logic [7:0] since, next_since;
    logic [9:0] hi_cnt, next_hi_cnt;
    logic [4:0] cl, next_cl;
    logic [63:0] rd_hist, next_rd_hist;
    assign rise = ck & ~ck_d;
    assign is_rd = rise && cmd == srb_pkg::srb_cmd_rd;
    assign is_mrs = rise && cmd == srb_pkg::srb_cmd_mrs;
    always_comb begin
        next_rpre2 = is_mrs ? addr[`SRB_MR_RPRE2_BIT] : rpre2;
        next_al = is_mrs ? addr[`SRB_MR_AL_LSB +: 5] : al;
        next_cl = is_mrs ? addr[`SRB_MR_CL_LSB +: 5] : cl;
        // Bit n marks a read seen n link clock rises back.
        next_rd_hist = rise ? {rd_hist[62:0], is_rd} : rd_hist;
        next_since = since;
        if (is_rd)
            next_since = 8'h01;
        else if (rise && since != 8'hFF)
            next_since = since + 8'h01;
        next_hi_cnt = dq_oe ? hi_cnt + 10'h001 : 10'h000;
    end
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ck_d <= 1'b0;
            rpre2 <= 1'b0;
            al <= `SRB_AL_RST;
            since <= 8'hFF;
            hi_cnt <= 10'h000;
            cl <= `SRB_CL_RST;
            rd_hist <= 64'h0;
        end else begin
            ck_d <= ck;
            rpre2 <= next_rpre2;
            al <= next_al;
            since <= next_since;
            hi_cnt <= next_hi_cnt;
            cl <= next_cl;
            rd_hist <= next_rd_hist;
        end
    end
    a_rd_ccd_min: assert property (is_rd |-> since >= `SRB_CCD_MIN)
        else $error("read commands too close");
    a_rd_ccd_ban: assert property (
        is_rd && rpre2 |-> since != `SRB_CCD_BAN_2PRE)
        else $error("read spacing of five with long preamble");
    a_pre_gap: assert property (
        rise && cmd == srb_pkg::srb_cmd_pre |-> since >= al + `SRB_RTP_CK)
        else $error("precharge too soon after read");
    a_cwl_bump: assert property (
        is_mrs && addr[`SRB_MR_WPRE2_BIT] |-> addr[17:14] > `SRB_CWL_MIN)
        else $error("write latency not raised");
    a_burst_len: assert property (
        $fell(dq_oe) |-> hi_cnt != 10'h000 && hi_cnt[4:0] == 5'h00)
        else $error("burst not a whole number of chops");
    a_first_word: assert property ($rose(dq_oe) |-> dqs && dqs_oe)
        else $error("first word without strobe high");
    a_pre_low: assert property (dqs_oe && !dq_oe |-> !dqs)
        else $error("strobe high in preamble");
    a_pre_len: assert property ($rose(dqs_oe) |-> !dq_oe [*8])
        else $error("preamble too short");
    a_word_hold: assert property (
        dq_oe && $changed(dqs) |=> ($stable(dq) && $stable(dqs)) [*7])
        else $error("data word shorter than half a link clock");
    a_ck_half: assert property ($rose(ck) |-> ck [*8] ##1 !ck)
        else $error("link clock high time wrong");
    a_rd_latency: assert property (
        $rose(dq_oe) |-> rd_hist[6'(al) + 6'(cl)])
        else $error("first data word not at read latency");
endmodule : srb_link_chk

/* dv/testbench.sv */
// Purpose: Drives both link ends through the controller registers.
// Assumes: Each Wishbone request is answered with a one-cycle ack.
// Notes: A watcher process compares read data and bank state.
`timescale 1ns/10ps
`include "srb_params.svh"
module testbench;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, rd, w_e, w_m, rq[$], mq[$];
    logic wb_ack_o, busy;
    logic bank_req = 1'b0;
    logic [3:0] bank_open, bq[$];
    logic [3:0] exp_open = 4'h0;
    int error_cnt = 0;
    int total_checks = 0;
    integer seed = 32'he85d;
    always #4 ref_clk = ~ref_clk;
    srb_link_if srb_link_if_i ();
    srb_ctrl srb_ctrl_i (.ref_clk(ref_clk), .reset(reset),
        .link(srb_link_if_i.ctl), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
    srb_device srb_device_i (.ref_clk(ref_clk), .reset(reset),
        .link(srb_link_if_i.dev), .bank_open(bank_open), .busy(busy));
    srb_link_chk srb_link_chk_i (.ref_clk(ref_clk), .reset(reset),
        .ck(srb_link_if_i.ck), .cmd(srb_link_if_i.cmd),
        .ba(srb_link_if_i.ba), .addr(srb_link_if_i.addr),
        .dq(srb_link_if_i.dq), .dq_oe(srb_link_if_i.dq_oe),
        .dqs(srb_link_if_i.dqs), .dqs_oe(srb_link_if_i.dqs_oe));
    task automatic final_report;
        if (error_cnt == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    task automatic give_up;
        error_cnt++;
        final_report();
    endtask : give_up
    task automatic chk_reg(input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED wb_dat_o expected %h seen %h", e, g);
        end
    endtask : chk_reg
    task automatic chk_bank(input logic [3:0] e, input logic [3:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED bank_open expected %h seen %h", e, g);
        end
    endtask : chk_bank
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        @(posedge ref_clk);
        while (wb_ack_o !== 1'b1) begin
            n++;
            if (n > 20)
                give_up();
            @(posedge ref_clk);
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge ref_clk);
    endtask : wb
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                          input logic [31:0] m);
        rq.push_back(e);
        mq.push_back(m);
        wb(1'b0, a, 32'h0);
    endtask : rd_chk
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            rd_chk(`SRB_REG_STAT, 32'h0, 32'h0);
            n++;
            if (n > 300)
                give_up();
        end while (rd[0] !== 1'b0);
    endtask : wait_idle
    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (busy !== lvl) begin
            n++;
            if (n > 1000)
                give_up();
            @(posedge ref_clk);
        end
    endtask : wait_busy
    task automatic send(input logic [2:0] c, input logic [1:0] b,
                        input logic [17:0] a);
        wait_idle();
        wb(1'b1, `SRB_REG_CMD, {9'h000, a, b, c});
    endtask : send
    task automatic bank_chk;
        bq.push_back(exp_open);
        bank_req <= 1'b1;
        @(posedge ref_clk);
        bank_req <= 1'b0;
    endtask : bank_chk
    task automatic do_read(input logic [1:0] b, input logic [9:0] col,
                           input logic a10, input logic a12,
                           input logic [3:0] nb);
        logic [63:0] w;
        logic [2:0] c;
        int n;
        for (int i = 0; i < 8; i++) begin
            c = col[2:0] + i[2:0];
            w[i*8 +: 8] = {col[7:3], c} ^ {b, 6'h2A};
        end
        send(srb_pkg::srb_cmd_rd, b, {5'h00, a12, 1'b0, a10, col});
        n = 0;
        do begin
            rd_chk(`SRB_REG_STAT, 32'h0, 32'h0);
            n++;
            if (n > 400)
                give_up();
        end while (rd[0] !== 1'b0 || rd[4:1] < nb);
        wait_busy(1'b0);
        rd_chk(`SRB_REG_STAT, {27'h0, nb, 1'b0}, 32'h1F);
        rd_chk(`SRB_REG_RD_LO, w[31:0], 32'hFFFFFFFF);
        if (nb == 4'h8)
            rd_chk(`SRB_REG_RD_HI, w[63:32], 32'hFFFFFFFF);
        if (a10)
            exp_open[b] = 1'b0;
        bank_chk();
    endtask : do_read
    always @(posedge ref_clk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rq.size() > 0) begin
            w_e = rq.pop_front();
            w_m = mq.pop_front();
            if (w_m != 32'h0)
                chk_reg(w_e, wb_dat_o & w_m);
        end
        if (bank_req === 1'b1)
            chk_bank(bq.pop_front(), bank_open);
    end
    initial begin
        logic [1:0] bl, b;
        logic [4:0] cl, al;
        logic [3:0] nb;
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        rd_chk(8'h40, 32'h0, 32'hFFFFFFFF);
        rd_chk(`SRB_REG_STAT, 32'h0, 32'hFFFFFFFF);
        send(srb_pkg::srb_cmd_act, 2'h1, 18'h0);
        exp_open[1] = 1'b1;
        do_read(2'h1, 10'h3FD, 1'b0, 1'b0, 4'h8);
        for (int m = 0; m < 3; m++) begin
            bl = m[1:0];
            cl = 5'd5 + 5'($random(seed) & 7);
            al = 5'($random(seed) & 3);
            send(srb_pkg::srb_cmd_mrs, 2'h0,
                 {4'h9, 1'b1, 1'($random(seed)), al, cl, bl});
            for (int k = 0; k < 2; k++) begin
                b = 2'($random(seed));
                send(srb_pkg::srb_cmd_act, b, 18'h0);
                exp_open[b] = 1'b1;
                nb = (bl == `SRB_BL_FIXED4 || (bl == `SRB_BL_OTF && k == 0))
                    ? 4'h4 : 4'h8;
                do_read(b, 10'($random(seed)), 1'($random(seed)), k[0],
                        nb);
            end
            send(srb_pkg::srb_cmd_rd, b, 18'h00010);
            if (m == 1) begin
                // Lets the next read fall due five link clocks later.
                wait_idle();
                repeat (62) @(posedge ref_clk);
            end
            send(srb_pkg::srb_cmd_rd, b, 18'h00028);
            send(srb_pkg::srb_cmd_pre, b, 18'h0);
            exp_open[b] = 1'b0;
            wait_idle();
            wait_busy(1'b1);
            wait_busy(1'b0);
            bank_chk();
        end
        final_report();
    end
endmodule : testbench

/* src/srb_ctrl.sv */
// Purpose: Controller end: makes the link clock and issues commands.
// Assumes: Software writes one command word at a time over Wishbone.
// Notes: Spacing checks delay a command; they never drop it.
`timescale 1ns/10ps
`include "srb_params.svh"

module srb_ctrl (
    input wire logic ref_clk,
    input wire logic reset,
    srb_link_if.ctl link,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    logic [3:0] div;
    logic ck;
    logic [2:0] cmd;
    logic [1:0] ba;
    logic [17:0] addr;
    logic pend;
    logic [22:0] pword;
    logic [7:0] since_rd;
    logic [4:0] al;
    logic rpre2;
    logic [7:0] rbuf [0:7];
    logic [3:0] rcnt;
    logic [9:0] cap1;
    logic [9:0] cap2;
    logic dqs_last;

    logic [3:0] next_div;
    logic next_ck;
    logic [2:0] next_cmd;
    logic [1:0] next_ba;
    logic [17:0] next_addr;
    logic next_pend;
    logic [22:0] next_pword;
    logic [7:0] next_since_rd;
    logic [4:0] next_al;
    logic next_rpre2;
    logic [7:0] next_rbuf [0:7];
    logic [3:0] next_rcnt;
    logic [31:0] next_dat;
    logic next_ack;

    logic tick;
    logic go;
    logic [17:0] mrs_addr;
    srb_pkg::srb_cmd_t pcmd;
    logic wb_req;

    assign tick = (div == `SRB_CK_HALF - 4'd1);
    assign pcmd = srb_pkg::srb_cmd_t'(pword[2:0]);
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    always_comb begin
        mrs_addr = pword[22:5];
        // A two-clock write preamble raises a write latency of SRB_CWL_MIN by one clock.
        if (mrs_addr[`SRB_MR_WPRE2_BIT] &&
                mrs_addr[`SRB_MR_CWL_LSB +: 4] == `SRB_CWL_MIN) begin
            mrs_addr[`SRB_MR_CWL_LSB +: 4] = `SRB_CWL_MIN + 4'd1;
        end
        case (pcmd)
            srb_pkg::srb_cmd_rd: go = since_rd >= `SRB_CCD_MIN &&
                !(rpre2 && since_rd == `SRB_CCD_BAN_2PRE);
            srb_pkg::srb_cmd_pre: go = since_rd >=
                8'(al) + 8'(`SRB_RTP_CK);
            default: go = 1'b1;
        endcase
    end

    always_comb begin
        next_div = tick ? 4'd0 : div + 4'd1;
        next_ck = tick ? ~ck : ck;
        next_cmd = cmd;
        next_ba = ba;
        next_addr = addr;
        next_pend = pend;
        next_pword = pword;
        next_since_rd = since_rd;
        next_al = al;
        next_rpre2 = rpre2;
        next_rbuf = rbuf;
        next_rcnt = rcnt;
        next_dat = wb_dat_o;
        next_ack = wb_req;
        if (tick && !ck && since_rd != 8'hFF) begin
            next_since_rd = since_rd + 8'd1;
        end
        // Commands change on the falling link edge, held one whole clock.
        if (tick && ck) begin
            next_cmd = 3'(srb_pkg::srb_cmd_nop);
            if (pend && go) begin
                next_pend = 1'b0;
                next_cmd = pword[2:0];
                next_ba = pword[4:3];
                next_addr = (pcmd == srb_pkg::srb_cmd_mrs) ?
                    mrs_addr : pword[22:5];
                if (pcmd == srb_pkg::srb_cmd_rd) begin
                    next_since_rd = 8'd0;
                    next_rcnt = 4'd0;
                end
                if (pcmd == srb_pkg::srb_cmd_mrs) begin
                    next_al = mrs_addr[`SRB_MR_AL_LSB +: 5];
                    next_rpre2 = mrs_addr[`SRB_MR_RPRE2_BIT];
                end
            end
        end
        if (cap2[8] != dqs_last && cap2[9] && rcnt < 4'd8) begin
            next_rbuf[rcnt[2:0]] = cap2[7:0];
            next_rcnt = rcnt + 4'd1;
        end
        // A write takes effect at the edge where the master sees ack high.
        if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
                wb_adr_i == `SRB_REG_CMD && wb_sel_i == 4'hF && !pend) begin
            next_pend = 1'b1;
            next_pword = wb_dat_i[22:0];
        end
        if (wb_req) begin
            next_dat = 32'h0000_0000;
            if (!wb_we_i) begin
                case (wb_adr_i)
                    `SRB_REG_CMD: next_dat = {9'h000, pword};
                    `SRB_REG_STAT: next_dat = {27'h0, rcnt, pend};
                    `SRB_REG_RD_LO:
                        next_dat = {rbuf[3], rbuf[2], rbuf[1], rbuf[0]};
                    `SRB_REG_RD_HI:
                        next_dat = {rbuf[7], rbuf[6], rbuf[5], rbuf[4]};
                    default: next_dat = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            div <= 4'h0;
            ck <= 1'b0;
            cmd <= 3'h0;
            ba <= 2'h0;
            addr <= 18'h00000;
            pend <= 1'b0;
            pword <= 23'h000000;
            since_rd <= 8'hFF;
            al <= `SRB_AL_RST;
            rpre2 <= 1'b0;
            for (int i = 0; i < 8; i++) begin
                rbuf[i] <= 8'h00;
            end
            rcnt <= 4'h0;
            cap1 <= 10'h000;
            cap2 <= 10'h000;
            dqs_last <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            wb_ack_o <= 1'b0;
        end else begin
            div <= next_div;
            ck <= next_ck;
            cmd <= next_cmd;
            ba <= next_ba;
            addr <= next_addr;
            pend <= next_pend;
            pword <= next_pword;
            since_rd <= next_since_rd;
            al <= next_al;
            rpre2 <= next_rpre2;
            rbuf <= next_rbuf;
            rcnt <= next_rcnt;
            cap1 <= {link.dq_oe, link.dqs, link.dq};
            cap2 <= cap1;
            dqs_last <= cap2[8];
            wb_dat_o <= next_dat;
            wb_ack_o <= next_ack;
        end
    end

    assign link.ck = ck;
    assign link.cmd = cmd;
    assign link.ba = ba;
    assign link.addr = addr;

endmodule : srb_ctrl

/* src/srb_device.sv */
// Purpose: Device end of the read burst link: burst decode and data out.
// Assumes: Link clock far slower than ref_clk; every pin synchronised.
// Notes: Read data is a fixed function of bank and column.
`timescale 1ns/10ps
`include "srb_params.svh"

module srb_device (
    input wire logic ref_clk,
    input wire logic reset,
    srb_link_if.dev link,
    output logic [3:0] bank_open,
    output logic busy
);
    localparam int PW = 24;

    logic [PW-1:0] sync1;
    logic [PW-1:0] sync2;
    logic ck_last;
    logic ck_rise;
    logic ck_fall;
    srb_pkg::srb_cmd_t cmd_in;
    logic [1:0] ba_in;
    logic [17:0] addr_in;

    logic [1:0] bl_mode;
    logic [4:0] cl;
    logic [4:0] al;
    logic rpre2;
    srb_pkg::srb_rd_t pipe [0:`SRB_PIPE_DEPTH-1];
    srb_pkg::srb_rd_t cur;
    srb_pkg::srb_dq_st_t st;
    logic [2:0] beat;
    logic [2:0] left;
    logic [7:0] dq;
    logic dqs;

    logic [1:0] next_bl_mode;
    logic [4:0] next_cl;
    logic [4:0] next_al;
    logic next_rpre2;
    logic [3:0] next_bank_open;
    srb_pkg::srb_rd_t next_pipe [0:`SRB_PIPE_DEPTH-1];
    srb_pkg::srb_rd_t next_cur;
    srb_pkg::srb_dq_st_t next_st;
    logic [2:0] next_beat;
    logic [2:0] next_left;
    logic [7:0] next_dq;
    logic next_dqs;

    logic [5:0] rl;
    srb_pkg::srb_rd_t tap_data;
    srb_pkg::srb_rd_t tap_pre1;
    srb_pkg::srb_rd_t tap_pre2;
    srb_pkg::srb_rd_t entry;

    // Chop decision from the mode field and A12 of the command.
    function automatic logic is_bc4(input logic [1:0] mode,
                                    input logic a12);
        logic r;
        r = 1'b0;
        case (mode)
            `SRB_BL_FIXED8: r = 1'b0;
            `SRB_BL_FIXED4: r = 1'b1;
            `SRB_BL_OTF: r = ~a12;
            default: r = 1'b0;
        endcase
        return r;
    endfunction : is_bc4

    // Word for one beat: column steps through the burst and wraps in eight.
    function automatic logic [7:0] beat_word(input srb_pkg::srb_rd_t b,
                                             input logic [2:0] n);
        logic [9:0] c;
        c = {b.col[9:3], 3'(b.col[2:0] + n)};
        return c[7:0] ^ {b.ba, 6'h2A};
    endfunction : beat_word

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sync1 <= '0;
            sync2 <= '0;
            ck_last <= 1'b0;
        end else begin
            sync1 <= {link.ck, link.cmd, link.ba, link.addr};
            sync2 <= sync1;
            ck_last <= sync2[PW-1];
        end
    end

    assign ck_rise = sync2[PW-1] & ~ck_last;
    assign ck_fall = ~sync2[PW-1] & ck_last;
    assign cmd_in = srb_pkg::srb_cmd_t'(sync2[22:20]);
    assign ba_in = sync2[19:18];
    assign addr_in = sync2[17:0];

    assign rl = 6'(al) + 6'(cl);
    assign tap_data = pipe[5'(rl - 6'd1)];
    assign tap_pre1 = pipe[5'(rl - 6'd2)];
    assign tap_pre2 = pipe[5'(rl - 6'd3)];

    always_comb begin
        entry.v = (cmd_in == srb_pkg::srb_cmd_rd);
        entry.bc4 = is_bc4(bl_mode, addr_in[`SRB_A12_BIT]);
        entry.ap = addr_in[`SRB_A10_BIT];
        entry.ba = ba_in;
        entry.col = addr_in[`SRB_COL_MSB:0];
    end

    always_comb begin
        next_bl_mode = bl_mode;
        next_cl = cl;
        next_al = al;
        next_rpre2 = rpre2;
        next_bank_open = bank_open;
        next_pipe = pipe;
        next_cur = cur;
        next_st = st;
        next_beat = beat;
        next_left = left;
        next_dq = dq;
        next_dqs = dqs;
        if (ck_rise) begin
            next_pipe[0] = entry;
            for (int i = 1; i < `SRB_PIPE_DEPTH; i++) begin
                next_pipe[i] = pipe[i-1];
            end
            case (cmd_in)
                srb_pkg::srb_cmd_mrs: begin
                    next_bl_mode = addr_in[`SRB_MR_BL_LSB +: 2];
                    next_cl = addr_in[`SRB_MR_CL_LSB +: 5];
                    next_al = addr_in[`SRB_MR_AL_LSB +: 5];
                    next_rpre2 = addr_in[`SRB_MR_RPRE2_BIT];
                end
                srb_pkg::srb_cmd_act: next_bank_open[ba_in] = 1'b1;
                srb_pkg::srb_cmd_pre: next_bank_open[ba_in] = 1'b0;
                default: next_bank_open = bank_open;
            endcase
            if (tap_data.v) begin
                // A burst due now wins over one still running.
                next_st = srb_pkg::srb_st_data;
                next_cur = tap_data;
                next_dq = beat_word(tap_data, 3'd0);
                next_dqs = 1'b1;
                next_beat = 3'd1;
                next_left = tap_data.bc4 ? 3'd3 : 3'd7;
            end else if (st == srb_pkg::srb_st_data && left != 3'd0) begin
                next_dq = beat_word(cur, beat);
                next_dqs = 1'b1;
                next_beat = beat + 3'd1;
                next_left = left - 3'd1;
            end else if (tap_pre1.v || (rpre2 && tap_pre2.v)) begin
                // Strobe is driven low one or two clocks before data.
                next_st = srb_pkg::srb_st_pre;
                next_dqs = 1'b0;
            end else begin
                next_st = srb_pkg::srb_st_idle;
                next_dqs = 1'b0;
            end
        end else if (ck_fall) begin
            if (st == srb_pkg::srb_st_data && left != 3'd0) begin
                next_dq = beat_word(cur, beat);
                next_dqs = 1'b0;
                next_beat = beat + 3'd1;
                next_left = left - 3'd1;
            end
        end
        // The bank closes in the same cycle as the last word is driven onto dq.
        if (st == srb_pkg::srb_st_data && left == 3'd1 && cur.ap &&
                next_left == 3'd0) begin
            next_bank_open[cur.ba] = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            bl_mode <= `SRB_BL_RST;
            cl <= `SRB_CL_RST;
            al <= `SRB_AL_RST;
            rpre2 <= 1'b0;
            bank_open <= 4'h0;
            for (int i = 0; i < `SRB_PIPE_DEPTH; i++) begin
                pipe[i] <= '0;
            end
            cur <= '0;
            st <= srb_pkg::srb_st_idle;
            beat <= 3'h0;
            left <= 3'h0;
            dq <= 8'h00;
            dqs <= 1'b0;
        end else begin
            bl_mode <= next_bl_mode;
            cl <= next_cl;
            al <= next_al;
            rpre2 <= next_rpre2;
            bank_open <= next_bank_open;
            pipe <= next_pipe;
            cur <= next_cur;
            st <= next_st;
            beat <= next_beat;
            left <= next_left;
            dq <= next_dq;
            dqs <= next_dqs;
        end
    end

    assign link.dq = dq;
    assign link.dqs = dqs;
    assign link.dq_oe = (st == srb_pkg::srb_st_data);
    assign link.dqs_oe = (st != srb_pkg::srb_st_idle);
    assign busy = (st != srb_pkg::srb_st_idle);

endmodule : srb_device

/* src/srb_link_if.sv */
// Purpose: Link between the memory controller and the device.
// Assumes: Only the device drives data and strobe in this read path.
// Notes: The enables show when the device drives dq and dqs.
`timescale 1ns/10ps
interface srb_link_if;
    logic ck;
    logic [2:0] cmd;
    logic [1:0] ba;
    logic [17:0] addr;
    logic [7:0] dq;
    logic dq_oe;
    logic dqs;
    logic dqs_oe;

    modport dev (
        input ck,
        input cmd,
        input ba,
        input addr,
        output dq,
        output dq_oe,
        output dqs,
        output dqs_oe
    );

    modport ctl (
        output ck,
        output cmd,
        output ba,
        output addr,
        input dq,
        input dq_oe,
        input dqs,
        input dqs_oe
    );
endinterface : srb_link_if

/* src/srb_params.svh */
// Purpose: Constants for the read burst link between controller and device.
// Assumes: Reference clock of 125 MHz; link clock made by the controller.
// Notes: Field positions refer to the link address bus unless stated.
`ifndef SRB_PARAMS_SVH
`define SRB_PARAMS_SVH

// Reference clock period and link clock divider.
`define SRB_REF_PS 8000
`define SRB_CK_HALF 4'd8
`define SRB_CK_PS (2 * 8 * `SRB_REF_PS)

// Address bits sampled with a READ command.
`define SRB_A10_BIT 10
`define SRB_A12_BIT 12
`define SRB_COL_MSB 9

// Mode register fields carried on the address bus of a MRS command.
`define SRB_MR_BL_LSB 0
`define SRB_MR_CL_LSB 2
`define SRB_MR_AL_LSB 7
`define SRB_MR_RPRE2_BIT 12
`define SRB_MR_WPRE2_BIT 13
`define SRB_MR_CWL_LSB 14

// Burst length selections in mode register 0 bits 1:0.
`define SRB_BL_FIXED8 2'h0
`define SRB_BL_OTF 2'h1
`define SRB_BL_FIXED4 2'h2

// Mode reset values and the minimum write latency.
`define SRB_BL_RST 2'h0
`define SRB_CL_RST 5'h0B
`define SRB_AL_RST 5'h00
`define SRB_CWL_MIN 4'h9

// Command spacing in link clocks; SRB_RTP_NS_X10 is in tenths of a ns.
`define SRB_CCD_MIN 8'd4
`define SRB_CCD_BAN_2PRE 8'd5
`define SRB_RTP_MIN_CK 4
`define SRB_RTP_NS_X10 75
`define SRB_RTP_CK_RAW ((`SRB_RTP_NS_X10 * 100 + `SRB_CK_PS - 1) / `SRB_CK_PS)
`define SRB_RTP_CK ((`SRB_RTP_CK_RAW > `SRB_RTP_MIN_CK) ? \
    `SRB_RTP_CK_RAW : `SRB_RTP_MIN_CK)

// Depth of the device read latency pipe, in link clocks.
`define SRB_PIPE_DEPTH 32

// Controller register byte offsets.
`define SRB_REG_CMD 8'h00
`define SRB_REG_STAT 8'h04
`define SRB_REG_RD_LO 8'h08
`define SRB_REG_RD_HI 8'h0C

`endif

/* src/srb_pkg.sv */
// Purpose: Types shared by both ends of the read burst link.
// Assumes: Nothing beyond the parameter header.
// Notes: Command codes are the link encoding.
package srb_pkg;

    typedef enum logic [2:0] {
        srb_cmd_nop,
        srb_cmd_act,
        srb_cmd_rd,
        srb_cmd_pre,
        srb_cmd_mrs
    } srb_cmd_t;

    typedef enum logic [1:0] {
        srb_st_idle,
        srb_st_pre,
        srb_st_data
    } srb_dq_st_t;

    typedef struct packed {
        logic v;
        logic bc4;
        logic ap;
        logic [1:0] ba;
        logic [9:0] col;
    } srb_rd_t;

endpackage : srb_pkg
